// [hdl/islh_host.sv]
// Strobed register access and the placing of the registers were chosen for this implementation.
module islh_host
  import islh_pkg::*;
#(
  parameter int unsigned REF_HALF_CYC = EXT_REF_HALF_CYC
) (
  // Clock and reset
  input  wire logic              clock_i,
  input  wire logic              rst_b_i,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  // Serial control port
  output logic                   control_port_select_n_o,
  output logic                   control_port_clock_o,
  output logic                   control_port_serial_in_o,
  input  wire logic              control_port_serial_out_i,
  input  wire logic              transceiver_interrupt_n_i,
  // TDM link, two-way pins
  input  wire logic              tdm_bit_clock_pin_i,
  output logic                   tdm_bit_clock_pin_o,
  output logic                   tdm_bit_clock_pin_oe_b_o,
  input  wire logic              receive_frame_sync_i,
  output logic                   receive_frame_sync_o,
  output logic                   receive_frame_sync_oe_b_o,
  input  wire logic              transmit_frame_sync_i,
  output logic                   transmit_frame_sync_o,
  output logic                   transmit_frame_sync_oe_b_o,
  // TDM data and markers
  output logic                   tdm_data_in_o,
  input  wire logic              tdm_data_out_i,
  input  wire logic              transmit_superframe_marker_i,
  input  wire logic              receive_superframe_marker_i,
  input  wire logic              recovered_clock_i,
  // Straps and reference
  output logic                   timing_master_slave_strap_o,
  output logic                   gci_mode_strap_o,
  output logic                   gci_rate_strap_o,
  output logic                   external_frequency_reference_o
);

  localparam int unsigned REF_W = $clog2(REF_HALF_CYC + 1);
  localparam logic [4:0]  NB    = 5'(TDM_BITS);
  localparam logic [4:0]  SCPN  = 5'(SCP_WORD_BITS);

  initial begin
    if (REF_HALF_CYC < 1) begin
      $error("REF_HALF_CYC must be at least one");
    end
  end

  // ==========================================================
  // Input synchronisers
  logic [SYNC_W-1:0] sync_s;
  logic scp_out_s, irq_n_s, bclk_s, fsr_s, fsx_s, dout_s, sfx_s, sfr_s, rclk_s;

  islh_sync #(.WIDTH(SYNC_W)) u_sync (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .async_i ({control_port_serial_out_i, transceiver_interrupt_n_i, tdm_bit_clock_pin_i,
               receive_frame_sync_i, transmit_frame_sync_i, tdm_data_out_i,
               transmit_superframe_marker_i, receive_superframe_marker_i, recovered_clock_i}),
    .sync_o  (sync_s)
  );

  assign {scp_out_s, irq_n_s, bclk_s, fsr_s, fsx_s, dout_s, sfx_s, sfr_s, rclk_s} = sync_s;

  // ==========================================================
  // Registers written by software
  logic [CTRL_W-1:0]        ctrl_q;
  logic [SCP_WORD_BITS-1:0] scp_tx_q;
  logic [TDM_BITS-1:0]      tdm_tx_q;
  logic [HALF_W-1:0]        tdm_half_q;
  logic [FLEN_W-1:0]        flen_q;
  logic [HALF_W-1:0]        scp_half_q;
  logic [HALF_W-1:0]        wr_half;
  logic [FLEN_W-1:0]        wr_flen;
  logic [HALF_W-1:0]        wr_scp;
  logic                     dev_master;
  logic                     gci;
  logic                     tdm_en;

  assign wr_half    = reg_wdata_i[CFG_HALF_LSB +: HALF_W];
  assign wr_flen    = reg_wdata_i[CFG_FLEN_LSB +: FLEN_W];
  assign wr_scp     = reg_wdata_i[CFG_SCP_LSB +: HALF_W];
  assign dev_master = ctrl_q[CTRL_DEV_MAS];
  assign gci        = ctrl_q[CTRL_GCI];
  assign tdm_en     = ctrl_q[CTRL_TDM_EN];

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_q     <= CTRL_RST;
      scp_tx_q   <= '0;
      tdm_tx_q   <= '0;
      tdm_half_q <= TDM_HALF_RST;
      flen_q     <= FLEN_RST;
      scp_half_q <= SCP_HALF_RST;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        REG_CTRL:   ctrl_q   <= reg_wdata_i[CTRL_W-1:0];
        REG_SCP_TX: scp_tx_q <= reg_wdata_i[SCP_WORD_BITS-1:0];
        REG_TDM_TX: tdm_tx_q <= reg_wdata_i[TDM_BITS-1:0];
        REG_TDM_CFG: begin
          tdm_half_q <= (wr_half < TDM_HALF_MIN) ? TDM_HALF_MIN :
                        (wr_half > TDM_HALF_MAX) ? TDM_HALF_MAX : wr_half;
          flen_q     <= (wr_flen < FLEN_MIN) ? FLEN_MIN : wr_flen;
          scp_half_q <= (wr_scp < SCP_HALF_LO) ? SCP_HALF_LO : wr_scp;
        end
        default: ;
      endcase
    end
  end

  assign timing_master_slave_strap_o = dev_master;
  assign gci_mode_strap_o            = ~gci;
  assign gci_rate_strap_o            = ctrl_q[CTRL_GCI_2048];

  // ==========================================================
  // Serial control port
  islh_scp_e                scp_st_q;
  logic [HALF_W-1:0]        scp_cnt_q;
  logic [4:0]               scp_bits_q;
  logic [SCP_WORD_BITS-1:0] scp_sh_q;
  logic [SCP_WORD_BITS-1:0] scp_rx_q;
  logic                     scp_bit_q;
  logic                     scp_tick;
  logic                     scp_start;

  assign scp_tick  = (scp_cnt_q == '0);
  assign scp_start = reg_wr_i && (reg_addr_i == REG_SCP_TX) && (scp_st_q == SCP_IDLE);

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scp_st_q  <= SCP_IDLE;
      scp_cnt_q <= '0;
    end else begin
      scp_cnt_q <= (scp_tick || scp_st_q == SCP_IDLE) ? scp_half_q - 8'h01 : scp_cnt_q - 8'h01;
      unique case (scp_st_q)
        SCP_IDLE: if (scp_start) scp_st_q <= SCP_LEAD;
        SCP_LEAD: if (scp_tick) scp_st_q <= SCP_LOW;
        SCP_LOW:  if (scp_tick) scp_st_q <= SCP_HIGH;
        SCP_HIGH: if (scp_tick) scp_st_q <= (scp_bits_q == '0) ? SCP_TAIL : SCP_LOW;
        SCP_TAIL: if (scp_tick) scp_st_q <= SCP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scp_sh_q   <= '0;
      scp_bits_q <= '0;
      scp_rx_q   <= '0;
      scp_bit_q  <= 1'b0;
    end else if (scp_start) begin
      scp_sh_q   <= reg_wdata_i[SCP_WORD_BITS-1:0];
      scp_bits_q <= SCPN;
    end else if (scp_tick && scp_st_q == SCP_LOW) begin
      scp_bit_q  <= scp_out_s;
      scp_bits_q <= scp_bits_q - 5'h01;
    end else if (scp_tick && scp_st_q == SCP_HIGH) begin
      scp_sh_q   <= {scp_sh_q[SCP_WORD_BITS-2:0], scp_bit_q};
      if (scp_bits_q == '0) begin
        scp_rx_q <= {scp_sh_q[SCP_WORD_BITS-2:0], scp_bit_q};
      end
    end
  end

  assign control_port_select_n_o  = (scp_st_q == SCP_IDLE);
  assign control_port_clock_o     = (scp_st_q != SCP_LOW);
  assign control_port_serial_in_o = (scp_st_q == SCP_IDLE) ? 1'b0 :
                                    scp_sh_q[SCP_WORD_BITS-1];

  // ==========================================================
  // Bit clock and frame sync generation for a slave device
  logic [HALF_W-1:0] gen_cnt_q;
  logic [FLEN_W-1:0] gen_pos_q;
  logic              gen_clk_q;
  logic              gen_fs_q;
  logic              gen_on;
  logic              gen_tick;

  assign gen_on   = tdm_en && !dev_master;
  assign gen_tick = gen_on && (gen_cnt_q == '0);

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gen_cnt_q <= '0;
      gen_clk_q <= 1'b0;
      gen_pos_q <= '0;
      gen_fs_q  <= 1'b0;
    end else if (!gen_on) begin
      gen_cnt_q <= '0;
      gen_clk_q <= 1'b0;
      gen_pos_q <= '0;
      gen_fs_q  <= 1'b0;
    end else begin
      gen_cnt_q <= gen_tick ? tdm_half_q - 8'h01 : gen_cnt_q - 8'h01;
      if (gen_tick) begin
        gen_clk_q <= ~gen_clk_q;
        if (!gen_clk_q) begin
          gen_pos_q <= (gen_pos_q == flen_q - 10'h001) ? '0 : gen_pos_q + 10'h001;
          gen_fs_q  <= (gen_pos_q == flen_q - 10'h001);
        end
      end
    end
  end

  assign tdm_bit_clock_pin_o        = gen_clk_q;
  assign tdm_bit_clock_pin_oe_b_o   = ~gen_on;
  assign receive_frame_sync_o       = gen_fs_q;
  assign receive_frame_sync_oe_b_o  = ~gen_on;
  assign transmit_frame_sync_o      = gen_fs_q;
  assign transmit_frame_sync_oe_b_o = ~gen_on;

  // ==========================================================
  // Link edges, from the device clock or our own
  logic bclk_prev_q;
  logic ext_rise, ext_fall;
  logic lrise, lfall;
  logic fsx_lvl, fsr_lvl;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bclk_prev_q <= 1'b0;
    end else begin
      bclk_prev_q <= bclk_s;
    end
  end

  assign ext_rise = bclk_s && !bclk_prev_q;
  assign ext_fall = !bclk_s && bclk_prev_q;
  assign lrise    = tdm_en && (dev_master ? ext_rise : (gen_tick && !gen_clk_q));
  assign lfall    = tdm_en && (dev_master ? ext_fall : (gen_tick && gen_clk_q));
  assign fsx_lvl  = dev_master ? fsx_s : gen_fs_q;
  assign fsr_lvl  = dev_master ? fsr_s : gen_fs_q;

  // ==========================================================
  // Transmit path toward the device
  logic [4:0]          tx_idx_q;
  logic [TDM_BITS-1:0] tx_frame_q;
  logic                fsx_prev_q;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_idx_q      <= NB;
      tx_frame_q    <= '0;
      fsx_prev_q    <= 1'b0;
      tdm_data_in_o <= 1'b0;
    end else begin
      if (lfall) begin
        fsx_prev_q <= fsx_lvl;
        if (fsx_lvl && !fsx_prev_q) begin
          tx_idx_q   <= '0;
          tx_frame_q <= tdm_tx_q;
        end
      end else if (lrise) begin
        if (tx_idx_q < NB) begin
          tdm_data_in_o <= tx_frame_q[TDM_BITS-1];
          tx_frame_q    <= {tx_frame_q[TDM_BITS-2:0], 1'b0};
          tx_idx_q      <= tx_idx_q + 5'h01;
        end else begin
          tdm_data_in_o <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Receive path from the device
  logic [4:0]          rx_idx_q;
  logic [TDM_BITS-1:0] rx_sh_q;
  logic [TDM_BITS-1:0] rx_word_q;
  logic                fsr_prev_q;
  logic                rx_done;

  assign rx_done = lfall && !(fsr_lvl && !fsr_prev_q) && (rx_idx_q == NB - 5'h01);

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_idx_q   <= NB;
      rx_sh_q    <= '0;
      rx_word_q  <= '0;
      fsr_prev_q <= 1'b0;
    end else if (lfall) begin
      fsr_prev_q <= fsr_lvl;
      if (fsr_lvl && !fsr_prev_q) begin
        rx_idx_q <= '0;
      end else if (rx_idx_q < NB) begin
        rx_sh_q  <= {rx_sh_q[TDM_BITS-2:0], dout_s};
        rx_idx_q <= rx_idx_q + 5'h01;
        if (rx_done) begin
          rx_word_q <= {rx_sh_q[TDM_BITS-2:0], dout_s};
        end
      end
    end
  end

  // ==========================================================
  // Sticky status flags, set wins over write-one clear
  logic sfx_prev_q, sfr_prev_q;
  logic tx_sf_q, rx_sf_q, frame_q;
  logic st_wr;
  logic sfx_hit, sfr_hit;

  assign st_wr   = reg_wr_i && (reg_addr_i == REG_STATUS);
  assign sfx_hit = !gci && sfx_s && !sfx_prev_q;
  assign sfr_hit = !gci && sfr_s && !sfr_prev_q;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sfx_prev_q <= 1'b0;
      sfr_prev_q <= 1'b0;
      tx_sf_q    <= 1'b0;
      rx_sf_q    <= 1'b0;
      frame_q    <= 1'b0;
    end else begin
      sfx_prev_q <= sfx_s;
      sfr_prev_q <= sfr_s;
      tx_sf_q    <= sfx_hit || (tx_sf_q && !(st_wr && reg_wdata_i[ST_TX_SF]));
      rx_sf_q    <= sfr_hit || (rx_sf_q && !(st_wr && reg_wdata_i[ST_RX_SF]));
      frame_q    <= rx_done || (frame_q && !(st_wr && reg_wdata_i[ST_FRAME]));
    end
  end

  // ==========================================================
  // External frequency reference
  logic [REF_W-1:0] ref_cnt_q;
  logic             ref_q;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ref_cnt_q <= '0;
      ref_q     <= 1'b0;
    end else if (!ctrl_q[CTRL_REF_EN]) begin
      ref_cnt_q <= '0;
      ref_q     <= 1'b0;
    end else if (ref_cnt_q == REF_W'(REF_HALF_CYC - 1)) begin
      ref_cnt_q <= '0;
      ref_q     <= ~ref_q;
    end else begin
      ref_cnt_q <= ref_cnt_q + REF_W'(1);
    end
  end

  assign external_frequency_reference_o = ref_q;

  // ==========================================================
  // Read port, data one cycle after the strobe
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] status_w;

  always_comb begin
    status_w              = '0;
    status_w[ST_SCP_BUSY] = (scp_st_q != SCP_IDLE);
    status_w[ST_IRQ]      = ~irq_n_s;
    status_w[ST_RX_SF]    = rx_sf_q;
    status_w[ST_TX_SF]    = tx_sf_q;
    status_w[ST_FRAME]    = frame_q;
    status_w[ST_RCLK]     = gci && rclk_s;
  end

  always_comb begin
    rd_mux = '0;
    unique case (reg_addr_i)
      REG_CTRL:    rd_mux[CTRL_W-1:0]        = ctrl_q;
      REG_SCP_TX:  rd_mux[SCP_WORD_BITS-1:0] = scp_tx_q;
      REG_SCP_RX:  rd_mux[SCP_WORD_BITS-1:0] = scp_rx_q;
      REG_STATUS:  rd_mux                    = status_w;
      REG_TDM_TX:  rd_mux[TDM_BITS-1:0]      = tdm_tx_q;
      REG_TDM_RX:  rd_mux[TDM_BITS-1:0]      = rx_word_q;
      REG_TDM_CFG: rd_mux = {scp_half_q, 6'h00, flen_q, tdm_half_q};
      default:     rd_mux = '0;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_mux;
    end else begin
      reg_rdata_o <= '0;
    end
  end

endmodule : islh_host

// [shared/islh_pkg.sv]
package islh_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ           = 40_000_000;
  localparam int unsigned SCP_MAX_HZ       = 4_096_000;
  localparam int unsigned EXT_REF_HZ       = 8_000;
  localparam int unsigned BCLK_MIN_HZ      = 512_000;
  // Least half period of the control port clock, rounded up
  localparam int unsigned SCP_HALF_MIN     = (CLK_HZ + 2 * SCP_MAX_HZ - 1) / (2 * SCP_MAX_HZ);
  // Half period of the external frequency reference
  localparam int unsigned EXT_REF_HALF_CYC = CLK_HZ / (2 * EXT_REF_HZ);

  // ==========================================================
  // Word sizes
  localparam int unsigned ADDR_W        = 5;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned SCP_WORD_BITS = 16;
  localparam int unsigned TDM_BITS      = 18;
  localparam int unsigned HALF_W        = 8;
  localparam int unsigned FLEN_W        = 10;
  localparam int unsigned SYNC_W        = 9;

  // ==========================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] REG_CTRL    = 5'h00;
  localparam logic [ADDR_W-1:0] REG_SCP_TX  = 5'h04;
  localparam logic [ADDR_W-1:0] REG_SCP_RX  = 5'h08;
  localparam logic [ADDR_W-1:0] REG_STATUS  = 5'h0c;
  localparam logic [ADDR_W-1:0] REG_TDM_TX  = 5'h10;
  localparam logic [ADDR_W-1:0] REG_TDM_RX  = 5'h14;
  localparam logic [ADDR_W-1:0] REG_TDM_CFG = 5'h18;

  // ==========================================================
  // Control fields
  localparam int unsigned CTRL_W        = 5;
  localparam int unsigned CTRL_DEV_MAS  = 0;
  localparam int unsigned CTRL_GCI      = 1;
  localparam int unsigned CTRL_GCI_2048 = 2;
  localparam int unsigned CTRL_REF_EN   = 3;
  localparam int unsigned CTRL_TDM_EN   = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h05;

  // Status fields
  localparam int unsigned ST_SCP_BUSY = 0;
  localparam int unsigned ST_IRQ      = 1;
  localparam int unsigned ST_RX_SF    = 2;
  localparam int unsigned ST_TX_SF    = 3;
  localparam int unsigned ST_FRAME    = 4;
  localparam int unsigned ST_RCLK     = 5;

  // Link configuration fields
  localparam int unsigned CFG_HALF_LSB = 0;
  localparam int unsigned CFG_FLEN_LSB = 8;
  localparam int unsigned CFG_SCP_LSB  = 24;
  localparam logic [HALF_W-1:0] TDM_HALF_MIN = 8'h03;
  localparam logic [HALF_W-1:0] TDM_HALF_RST = 8'h14;
  localparam logic [HALF_W-1:0] TDM_HALF_MAX = 8'(CLK_HZ / (2 * BCLK_MIN_HZ));
  localparam logic [FLEN_W-1:0] FLEN_MIN     = 10'h013;
  localparam logic [FLEN_W-1:0] FLEN_RST     = 10'h040;
  localparam logic [HALF_W-1:0] SCP_HALF_LO  = 8'(SCP_HALF_MIN);
  localparam logic [HALF_W-1:0] SCP_HALF_RST = 8'h0a;

  typedef enum logic [2:0] {
    SCP_IDLE = 3'b000,
    SCP_LEAD = 3'b001,
    SCP_LOW  = 3'b010,
    SCP_HIGH = 3'b011,
    SCP_TAIL = 3'b100
  } islh_scp_e;

endpackage : islh_pkg

// [hdl/islh_sync.sv]
module islh_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_b_i,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : islh_sync

// [tb/islh_host_chk.sv]
module islh_host_chk
  import islh_pkg::*;
(
  // Clock, reset and register port
  input wire logic              clock_i,
  input wire logic              rst_b_i,
  input wire logic              reg_rd_i,
  input wire logic              reg_wr_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  // Control port and straps
  input wire logic              control_port_select_n_o,
  input wire logic              control_port_clock_o,
  input wire logic              control_port_serial_in_o,
  input wire logic              tdm_bit_clock_pin_oe_b_o,
  input wire logic              timing_master_slave_strap_o
);
  // ====================
  // Port checks
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  sel_idle_a: assert property (
    control_port_select_n_o |-> control_port_clock_o)
    else $error("control clock low while deselected");
  sel_hold_a: assert property (
    $fell(control_port_select_n_o) |-> !control_port_select_n_o [*8])
    else $error("select released too early");
  scp_rate_a: assert property (
    $changed(control_port_clock_o) |=> $stable(control_port_clock_o) [*4])
    else $error("control clock phase too short");
  din_hold_a: assert property (
    $rose(control_port_clock_o) |-> $stable(control_port_serial_in_o))
    else $error("serial data moved at capture edge");
  clk_sel_a: assert property (
    $changed(control_port_clock_o)
    |-> !control_port_select_n_o && !$past(control_port_select_n_o))
    else $error("control clock moved outside a transfer");
  rdata_idle_a: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == '0)
    else $error("read data outside its cycle");
  oe_master_a: assert property (
    timing_master_slave_strap_o && $past(timing_master_slave_strap_o)
    |-> tdm_bit_clock_pin_oe_b_o)
    else $error("bit clock driven against master device");
  strap_wr_a: assert property (
    $changed(timing_master_slave_strap_o) |-> $past(reg_wr_i))
    else $error("strap moved without a write");
endmodule : islh_host_chk

bind islh_host islh_host_chk u_chk (
  .clock_i                    (clock_i),
  .rst_b_i                    (rst_b_i),
  .reg_rd_i                   (reg_rd_i),
  .reg_wr_i                   (reg_wr_i),
  .reg_rdata_o                (reg_rdata_o),
  .control_port_select_n_o    (control_port_select_n_o),
  .control_port_clock_o       (control_port_clock_o),
  .control_port_serial_in_o   (control_port_serial_in_o),
  .tdm_bit_clock_pin_oe_b_o   (tdm_bit_clock_pin_oe_b_o),
  .timing_master_slave_strap_o(timing_master_slave_strap_o)
);

// [tb/islh_dev_model.sv]
module islh_dev_model
  import islh_pkg::*;
(
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  // Control port
  input  wire logic        sel_n_i,
  input  wire logic        sclk_i,
  input  wire logic        sdi_i,
  output logic             sdo_o,
  input  wire logic        irq_req_i,
  output logic             irq_n_o,
  output logic [15:0]      scp_cap_o,
  // TDM link
  input  wire logic        master_i,
  input  wire logic        gci_n_i,
  input  wire logic        bclk_i,
  input  wire logic        sync_i,
  output logic             bclk_o,
  output logic             sync_o,
  input  wire logic        din_i,
  output logic             dout_o,
  output logic             txm_o,
  output logic             rxm_o,
  output logic             rclk_o,
  input  wire logic [17:0] reply_i,
  output logic [17:0]      tdm_cap_o
);
  // ====================
  // Device behaviour
  localparam logic [15:0] SCP_REPLY = 16'hc3a5;
  logic       sclk_q;
  logic       bclk_q;
  logic [3:0] k_q;
  logic [3:0] div_q;
  logic [5:0] bitn_q;
  logic [1:0] fcnt_q;

  assign irq_n_o = !irq_req_i;
  assign txm_o = gci_n_i && fcnt_q == 2'h0 && bitn_q < 6'h04;
  assign rxm_o = txm_o;
  assign rclk_o = !gci_n_i && bclk_o;

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {sclk_q, bclk_q, sdo_o, bclk_o, sync_o, dout_o} <= 6'h21;
      {k_q, div_q, fcnt_q, scp_cap_o, tdm_cap_o} <= '0;
      bitn_q <= 6'h1e;
    end else begin
      sclk_q <= sclk_i;
      bclk_q <= bclk_i;
      // select, capture on rise, launch on fall
      if (sel_n_i) begin
        k_q <= 4'h0;
        sdo_o <= !sdo_o;
      end else if (sclk_i && !sclk_q) begin
        scp_cap_o <= {scp_cap_o[14:0], sdi_i};
      end else if (!sclk_i && sclk_q) begin
        sdo_o <= SCP_REPLY[4'hf - k_q];
        k_q <= k_q + 4'h1;
      end
      // master bit clock, 200 ns period
      div_q <= (div_q == 4'h3) ? 4'h0 : div_q + 4'h1;
      if (div_q == 4'h3 && master_i) begin
        bclk_o <= !bclk_o;
      end
      if (bclk_i && !bclk_q) begin
        sync_o <= master_i && bitn_q == 6'h1f;
        // data on rising edges, toggled otherwise
        dout_o <= (bitn_q < 6'd18) ? reply_i[5'd17 - bitn_q[4:0]] : !dout_o;
      end
      if (!bclk_i && bclk_q) begin
        if (sync_i) begin
          bitn_q <= 6'h00;
          fcnt_q <= fcnt_q + 2'h1;
        end else begin
          // sample on falling edges, slots only
          if (bitn_q < 6'd18) begin
            tdm_cap_o[5'd17 - bitn_q[4:0]] <= din_i;
          end
          if (bitn_q != 6'h3f) begin
            bitn_q <= bitn_q + 6'h01;
          end
        end
      end
    end
  end
endmodule : islh_dev_model

// [tb/tb.sv]
module tb
  import islh_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // Bench
  logic clock_i, rst_b_i, wr, rd, irq_req;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [17:0] reply, tdm_cap;
  logic [15:0] scp_cap;
  logic sel_n, sclk, sdi, sdo, irq_n, bc_h, bc_oe, fr_h, fr_oe, fx_h, fx_oe;
  logic din, dout, txm, rxm, rclk, mas, gci_n, rate, eref, bc_d, sy_d;
  wire bclk = bc_oe ? bc_d : bc_h;
  wire fsr = fr_oe ? sy_d : fr_h;
  wire fsx = fx_oe ? sy_d : fx_h;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;

  islh_host #(.REF_HALF_CYC(4)) dut (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .control_port_select_n_o(sel_n), .control_port_clock_o(sclk),
    .control_port_serial_in_o(sdi), .control_port_serial_out_i(sdo),
    .transceiver_interrupt_n_i(irq_n), .tdm_bit_clock_pin_i(bclk),
    .tdm_bit_clock_pin_o(bc_h), .tdm_bit_clock_pin_oe_b_o(bc_oe),
    .receive_frame_sync_i(fsr), .receive_frame_sync_o(fr_h),
    .receive_frame_sync_oe_b_o(fr_oe), .transmit_frame_sync_i(fsx),
    .transmit_frame_sync_o(fx_h), .transmit_frame_sync_oe_b_o(fx_oe),
    .tdm_data_in_o(din), .tdm_data_out_i(dout), .transmit_superframe_marker_i(txm),
    .receive_superframe_marker_i(rxm), .recovered_clock_i(rclk),
    .timing_master_slave_strap_o(mas), .gci_mode_strap_o(gci_n),
    .gci_rate_strap_o(rate), .external_frequency_reference_o(eref));

  islh_dev_model u_dev (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .sel_n_i(sel_n), .sclk_i(sclk), .sdi_i(sdi),
    .sdo_o(sdo), .irq_req_i(irq_req), .irq_n_o(irq_n), .scp_cap_o(scp_cap),
    .master_i(mas), .gci_n_i(gci_n), .bclk_i(bclk), .sync_i(fsx), .bclk_o(bc_d),
    .sync_o(sy_d), .din_i(din), .dout_o(dout), .txm_o(txm), .rxm_o(rxm),
    .rclk_o(rclk), .reply_i(reply), .tdm_cap_o(tdm_cap));

  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
    @(posedge clock_i);
  endtask : wr_reg

  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clock_i);
  endtask : rd_reg

  task automatic wait_st(input int b, input logic v);
    logic [DATA_W-1:0] s;
    int n;
    n = 0;
    rd_reg(REG_STATUS, s);
    while (s[b] !== v && n < 3000) begin
      rd_reg(REG_STATUS, s);
      n++;
    end
    chk("status wait", 32'(s[b]), 32'(v));
  endtask : wait_st

  task automatic frames(input int n);
    repeat (n) begin
      wr_reg(REG_STATUS, 32'h10);
      wait_st(ST_FRAME, 1'b1);
    end
  endtask : frames

  task automatic t_regs();
    logic [DATA_W-1:0] d;
    rd_reg(REG_CTRL, d);
    chk("ctrl reset", d, 32'(CTRL_RST));
    rd_reg(REG_TDM_CFG, d);
    chk("cfg reset", d, 32'h0a004014);
    wr_reg(5'h1c, 32'hffffffff);
    rd_reg(5'h1c, d);
    chk("unmapped", d, 32'h0);
    wr_reg(REG_TDM_CFG, 32'hffffffff);
    rd_reg(REG_TDM_CFG, d);
    chk("cfg clamp high", d, 32'hff03ff27);
    wr_reg(REG_TDM_CFG, 32'h0);
    rd_reg(REG_TDM_CFG, d);
    chk("cfg clamp low", d, 32'h05001303);
    wr_reg(REG_TDM_CFG, 32'h0a004014);
  endtask : t_regs

  task automatic t_scp();
    logic [DATA_W-1:0] d;
    wr_reg(REG_SCP_TX, 32'h0000a53c);
    wr_reg(REG_SCP_TX, 32'h0000ffff);
    wait_st(ST_SCP_BUSY, 1'b0);
    chk("scp word", 32'(scp_cap), 32'h0000a53c);
    rd_reg(REG_SCP_RX, d);
    chk("scp reply", d, 32'h0000c3a5);
  endtask : t_scp

  task automatic t_irq();
    logic [DATA_W-1:0] d;
    irq_req <= 1'b1;
    repeat (4) @(posedge clock_i);
    rd_reg(REG_STATUS, d);
    chk("irq set", 32'(d[ST_IRQ]), 32'h1);
    irq_req <= 1'b0;
    repeat (4) @(posedge clock_i);
    rd_reg(REG_STATUS, d);
    chk("irq clear", 32'(d[ST_IRQ]), 32'h0);
  endtask : t_irq

  task automatic t_link(input logic [4:0] c, input logic [17:0] tx, input logic [17:0] rx);
    logic [DATA_W-1:0] d;
    reply <= rx;
    wr_reg(REG_TDM_TX, 32'(tx));
    wr_reg(REG_CTRL, 32'(c));
    wr_reg(REG_STATUS, 32'h1c);
    frames(2);
    chk("link tx", 32'(tdm_cap), 32'(tx));
    rd_reg(REG_TDM_RX, d);
    chk("link rx", d, 32'(rx));
    chk("clock pin dir", 32'(bc_oe), 32'(c[CTRL_DEV_MAS]));
    chk("rate strap", 32'(rate), 32'(c[CTRL_GCI_2048]));
    if (c[CTRL_REF_EN]) begin
      @(posedge eref);
      repeat (3) @(posedge clock_i);
      #1 chk("ref high", 32'(eref), 32'h1);
      @(posedge clock_i);
      #1 chk("ref low", 32'(eref), 32'h0);
      @(posedge clock_i);
    end
  endtask : t_link

  task automatic t_marks(input logic gci, input logic [1:0] e);
    logic [DATA_W-1:0] d;
    wr_reg(REG_CTRL, {27'h0, 2'b11, 1'b1, gci, 1'b1});
    wr_reg(REG_STATUS, 32'h1c);
    frames(5);
    rd_reg(REG_STATUS, d);
    chk("markers", 32'(d[3:2]), 32'(e));
    chk("gci strap", 32'(gci_n), 32'(!gci));
  endtask : t_marks

  initial begin
    rst_b_i = 1'b0;
    {wr, rd, irq_req, addr, wdata, reply} = '0;
    repeat (4) @(posedge clock_i);
    rst_b_i <= 1'b1;
    @(posedge clock_i);
    t_regs();
    t_scp();
    t_irq();
    t_link(5'h1d, 18'h1e4a7, 18'h2b5c3);
    t_marks(1'b0, 2'b11);
    t_marks(1'b1, 2'b00);
    t_link(5'h10, 18'h0cafe, 18'h3a0f1);
    report_and_stop();
  end
endmodule : tb
